// file: include/dipd_pkg.sv
// Shared constants, register map and types of the digital input pulse detector
package dipd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int unsigned TICK_W = 18;

    ////////////////////////////////////////////////////////////////////////////
    // Inputs and debounce
    localparam int unsigned MAX_INPUTS = 12;
    localparam int unsigned MIN_INPUTS = 4;
    localparam int unsigned DEB_W = 7;
    localparam logic [6:0] DEBOUNCE_MIN_MS = 7'h01;
    localparam logic [6:0] DEBOUNCE_MAX_MS = 7'h64;
    localparam logic [6:0] DEBOUNCE_RST_MS = 7'h0A;
    localparam int unsigned CNT_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DEBOUNCE_OFS = 8'h04;
    localparam logic [7:0] ROUTE_OFS = 8'h08;
    localparam logic [7:0] LEVEL_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    localparam logic [7:0] FITTED_OFS = 8'h18;
    localparam logic [7:0] COUNTER_BASE = 8'h40;
    localparam logic [7:0] DEB_ALIAS_BASE = 8'h80;
    localparam logic [7:0] BLOCK_SPAN = 8'h30;

    ////////////////////////////////////////////////////////////////////////////
    // Status bit positions and reset values
    localparam int unsigned STATUS_W = 14;
    localparam int unsigned ST_DEMAND_BIT = 12;
    localparam int unsigned ST_WRAP_BIT = 13;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [11:0] ROUTE_RST = 12'h000;
    localparam logic [13:0] MASK_RST = 14'h0000;

    typedef struct packed {
        logic demand_sync;
        logic invert;
        logic transition_pulse_mode;
    } dipd_ctrl_t;

endpackage : dipd_pkg

// file: sim/dipd_contacts.sv
// Behavioural model of the external dry contacts, with optional contact chatter
`timescale 1ns/1ps
`default_nettype none
module dipd_contacts #(
    parameter int unsigned BOUNCE_CYC = 15
) (
    input wire logic clock,
    input wire logic [11:0] level_cmd,
    input wire logic bounce_en,
    output wire logic [11:0] contact_in
);
    logic [11:0] drv = 12'h000;
    logic [11:0] held = 12'h000;
    int unsigned ph = 0;
    int unsigned cnt = 0;

    assign contact_in = drv;

    ////////////////////////////////////////////////////////////////////////////
    // Chatter phases each shorter than one debounce period, so the filter must reject them
    always @(posedge clock) begin
        if (level_cmd == held || !bounce_en || ph == 5) begin
            held <= level_cmd;
            drv <= level_cmd;
            ph <= 0;
            cnt <= 0;
        end else begin
            drv <= (ph % 2 == 0) ? level_cmd : held;
            if (cnt == BOUNCE_CYC - 1) begin
                cnt <= 0;
                ph <= ph + 1;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : dipd_contacts
`default_nettype wire

// file: sim/tb.sv
// Self-checking testbench of the digital input pulse detector
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TC = 20;
    localparam int SETTLE = 240;
    localparam int LIMIT = 20000;

    logic clock;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [11:0] level_cmd = 12'h000;
    logic bounce_en = 1'b0;
    wire logic [11:0] contact_in;
    logic [31:0] rdata;
    logic [11:0] setpoint_event;
    logic demand_start;
    logic irq;
    logic [7:0] sp_cnt [12] = '{default: 8'h00};
    logic [7:0] dm_cnt = 8'h00;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    dipd_top #(.DI_COUNT(12), .TICK_CYCLES(TC)) dut (.clock(clock), .nrst(nrst),
        .contact_in(contact_in), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .setpoint_event(setpoint_event), .demand_start(demand_start), .irq(irq));
    dipd_contacts #(.BOUNCE_CYC(15)) partner (.clock(clock), .level_cmd(level_cmd),
        .bounce_en(bounce_en), .contact_in(contact_in));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event tally and hang guard
    always @(posedge clock) begin
        for (int i = 0; i < 12; i++) begin
            if (setpoint_event[i] === 1'b1) sp_cnt[i] <= sp_cnt[i] + 8'h01;
        end
        if (demand_start === 1'b1) dm_cnt <= dm_cnt + 8'h01;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd

    task automatic settle_to(input logic [11:0] lv);
        @(posedge clock);
        level_cmd <= lv;
        repeat (SETTLE) @(posedge clock);
        #1;
    endtask : settle_to

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_regs();
        rd(dipd_pkg::CTRL_OFS, 32'h0000_0000);
        rd(dipd_pkg::DEBOUNCE_OFS, 32'h0000_000A);
        rd(dipd_pkg::ROUTE_OFS, 32'h0000_0000);
        rd(dipd_pkg::MASK_OFS, 32'h0000_0000);
        rd(dipd_pkg::STATUS_OFS, 32'h0000_0000);
        rd(dipd_pkg::FITTED_OFS, 32'h0000_0FFF);
        rd(8'h3C, 32'h0000_0000);
        $display("test reset_regs done");
    endtask : t_reset_regs

    task automatic t_debounce_time();
        int n;
        n = 0;
        @(posedge clock);
        level_cmd <= 12'h001;
        while (setpoint_event[0] !== 1'b1 && n < 1000) begin
            @(posedge clock);
            #1;
            n++;
        end
        // Stable window of 10 to 11 ticks plus pipeline
        check(32'(n >= 10 * TC && n <= 11 * TC + 8), 32'h0000_0001);
        rd(dipd_pkg::LEVEL_OFS, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        settle_to(12'h000);
        $display("test debounce_time done");
    endtask : t_debounce_time

    task automatic t_debounce_regs();
        wr(8'h88, 32'h0000_00C8);
        rd(dipd_pkg::DEBOUNCE_OFS, 32'h0000_0064);
        rd(8'hAC, 32'h0000_0064);
        wr(dipd_pkg::DEBOUNCE_OFS, 32'h0000_0000);
        rd(8'h80, 32'h0000_0001);
        wr(8'h84, 32'h0000_0002);
        rd(dipd_pkg::DEBOUNCE_OFS, 32'h0000_0002);
        wr(dipd_pkg::LEVEL_OFS, 32'h0000_0FFF);
        rd(dipd_pkg::LEVEL_OFS, 32'h0000_0000);
        $display("test debounce_regs done");
    endtask : t_debounce_regs

    task automatic t_glitch();
        logic [7:0] b;
        b = sp_cnt[4];
        @(posedge clock);
        level_cmd <= 12'h010;
        // Shorter than two millisecond ticks
        repeat (30) @(posedge clock);
        level_cmd <= 12'h000;
        repeat (SETTLE) @(posedge clock);
        check(32'(sp_cnt[4] - b), 32'h0000_0000);
        rd(dipd_pkg::LEVEL_OFS, 32'h0000_0000);
        $display("test glitch done");
    endtask : t_glitch

    task automatic t_modes(input logic chatter);
        logic [1:0] m;
        logic [7:0] b;
        bounce_en <= chatter;
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            wr(dipd_pkg::CTRL_OFS, 32'(m));
            b = sp_cnt[1];
            settle_to(12'h002);
            check(32'(sp_cnt[1] - b), 32'(m[0] | !m[1]));
            b = sp_cnt[1];
            settle_to(12'h000);
            check(32'(sp_cnt[1] - b), 32'(m[0] | m[1]));
        end
        bounce_en <= 1'b0;
        $display("test modes done");
    endtask : t_modes

    task automatic t_counter_irq();
        logic [7:0] b;
        wr(dipd_pkg::CTRL_OFS, 32'h0000_0000);
        wr(dipd_pkg::ROUTE_OFS, 32'h0000_0001);
        wr(dipd_pkg::STATUS_OFS, 32'h0000_3FFF);
        wr(dipd_pkg::MASK_OFS, 32'h0000_2001);
        check(32'(irq), 32'h0000_0000);
        b = sp_cnt[0];
        settle_to(12'h001);
        check(32'(sp_cnt[0] - b), 32'h0000_0000);
        rd(dipd_pkg::COUNTER_BASE, 32'h0000_0001);
        rd(dipd_pkg::STATUS_OFS, 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        wr(dipd_pkg::STATUS_OFS, 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        wr(dipd_pkg::COUNTER_BASE, 32'h0000_FFFF);
        settle_to(12'h000);
        rd(dipd_pkg::COUNTER_BASE, 32'h0000_FFFF);
        settle_to(12'h001);
        rd(dipd_pkg::COUNTER_BASE, 32'h0000_0000);
        rd(dipd_pkg::STATUS_OFS, 32'h0000_2001);
        check(32'(irq), 32'h0000_0001);
        wr(dipd_pkg::MASK_OFS, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        settle_to(12'h000);
        wr(dipd_pkg::ROUTE_OFS, 32'h0000_0000);
        $display("test counter_irq done");
    endtask : t_counter_irq

    task automatic t_demand();
        logic [7:0] b;
        wr(dipd_pkg::CTRL_OFS, 32'h0000_0004);
        wr(dipd_pkg::STATUS_OFS, 32'h0000_3FFF);
        b = dm_cnt;
        settle_to(12'h002);
        check(32'(dm_cnt - b), 32'h0000_0000);
        settle_to(12'h003);
        check(32'(dm_cnt - b), 32'h0000_0001);
        rd(dipd_pkg::STATUS_OFS, 32'h0000_1003);
        settle_to(12'h000);
        check(32'(dm_cnt - b), 32'h0000_0001);
        $display("test demand done");
    endtask : t_demand

    task automatic t_all_inputs();
        logic [7:0] b [12];
        wr(dipd_pkg::CTRL_OFS, 32'h0000_0001);
        b = sp_cnt;
        settle_to(12'hFFF);
        rd(dipd_pkg::LEVEL_OFS, 32'h0000_0FFF);
        settle_to(12'h000);
        for (int i = 0; i < 12; i++) begin
            check(32'(sp_cnt[i] - b[i]), 32'h0000_0002);
        end
        $display("test all_inputs done");
    endtask : t_all_inputs

    task automatic results();
        $display("checks=%0d mismatches=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        t_reset_regs();
        t_debounce_time();
        t_debounce_regs();
        t_glitch();
        t_modes(1'b0);
        t_modes(1'b1);
        t_counter_irq();
        t_demand();
        t_all_inputs();
        results();
    end
endmodule : tb
`default_nettype wire

// file: verilog/dipd_debounce.sv
// Synchroniser and debounce filter for one contact input
`timescale 1ns/1ps
`default_nettype none
module dipd_debounce (
    input wire logic clock,
    input wire logic nrst,
    input wire logic tick,
    input wire logic raw,
    input wire logic [6:0] debounce_ms,
    output logic level,
    output logic rise,
    output logic fall
);
    logic sync1;
    logic sync2;
    logic [dipd_pkg::DEB_W-1:0] cnt;
    logic accept;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // Needs debounce_ms+1 ticks, so stability is at least the full time
    assign accept = tick && (sync2 != level) && (cnt >= debounce_ms);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (sync2 == level || accept) begin
            cnt <= '0;
        end else if (tick && cnt != dipd_pkg::DEBOUNCE_MAX_MS) begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= accept && sync2;
            fall <= accept && !sync2;
            if (accept) begin
                level <= sync2;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_stable_before_accept: assert property ($changed(level) |->
        $past(tick) && ($past(cnt) >= $past(debounce_ms)))
        else $error("level accepted before debounce time");
    a_edge_matches_level: assert property (rise |-> level && !$past(level))
        else $error("rise without a level change");
endmodule : dipd_debounce
`default_nettype wire

// file: verilog/dipd_tick.sv
// Millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
module dipd_tick #(
    parameter int unsigned TICK_CYCLES = dipd_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    output logic tick
);
    logic [dipd_pkg::TICK_W-1:0] cnt;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt == dipd_pkg::TICK_W'(TICK_CYCLES - 1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_tick_one_cycle: assert property (tick |=> !tick)
        else $error("tick longer than one cycle");
endmodule : dipd_tick
`default_nettype wire

// file: verilog/dipd_top.sv
// Digital input pulse detector: debounce, edge events, counters and registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Pulse mode gives one event per pulse
// - Transition mode gives events on both edges
// - Normal polarity: open-to-closed is the event
// - Inverting polarity: closed-to-open is the event
// - Transition mode ignores polarity
// - Level accepted after stable debounce time
// - One shared debounce time for all inputs
// - Four to twelve inputs fitted
// - Events go to setpoint or pulse counter
// - External sync: first input event starts demand
module dipd_top #(
    parameter int unsigned DI_COUNT = dipd_pkg::MAX_INPUTS,
    parameter int unsigned TICK_CYCLES = dipd_pkg::TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [11:0] contact_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic [11:0] setpoint_event,
    output logic demand_start,
    output logic irq
);
    localparam int unsigned N = dipd_pkg::MAX_INPUTS;
    // Inputs above the fitted count never produce events
    localparam logic [11:0] FITTED = 12'((13'h0001 << DI_COUNT) - 13'h0001);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    dipd_pkg::dipd_ctrl_t ctrl_q;
    logic [6:0] debounce_ms;
    logic [11:0] route;
    logic [13:0] status;
    logic [13:0] mask;
    logic [15:0] count_q [0:11];
    logic tick;
    logic [11:0] level;
    logic [11:0] rise;
    logic [11:0] fall;
    logic [11:0] event_vec;
    logic [11:0] count_wrap;
    logic [13:0] status_set;
    logic [13:0] status_clr;
    logic [31:0] read_mux;
    logic [6:0] next_debounce;
    logic wr_debounce;
    logic in_counters;
    logic in_aliases;
    logic [7:0] ofs_cnt;
    logic [7:0] ofs_alias;
    logic [3:0] cnt_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Tick and per-input filters
    dipd_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .nrst(nrst),
        .tick(tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_in
            dipd_debounce u_deb (
                .clock(clock),
                .nrst(nrst),
                .tick(tick),
                .raw(contact_in[gi]),
                .debounce_ms(debounce_ms),
                .level(level[gi]),
                .rise(rise[gi]),
                .fall(fall[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Edge selection
    always_comb begin
        if (ctrl_q.transition_pulse_mode) begin
            event_vec = (rise | fall) & FITTED;
        end else if (ctrl_q.invert) begin
            event_vec = fall & FITTED;
        end else begin
            event_vec = rise & FITTED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign ofs_cnt = addr - dipd_pkg::COUNTER_BASE;
    assign ofs_alias = addr - dipd_pkg::DEB_ALIAS_BASE;
    assign in_counters = (addr >= dipd_pkg::COUNTER_BASE) && (ofs_cnt < dipd_pkg::BLOCK_SPAN)
        && (addr[1:0] == 2'h0);
    assign in_aliases = (addr >= dipd_pkg::DEB_ALIAS_BASE) && (ofs_alias < dipd_pkg::BLOCK_SPAN)
        && (addr[1:0] == 2'h0);
    assign cnt_idx = ofs_cnt[5:2];
    // Every per-input alias lands in the one shared register
    assign wr_debounce = wr_en && (addr == dipd_pkg::DEBOUNCE_OFS || in_aliases);

    always_comb begin
        if (wdata < 32'(dipd_pkg::DEBOUNCE_MIN_MS)) begin
            next_debounce = dipd_pkg::DEBOUNCE_MIN_MS;
        end else if (wdata > 32'(dipd_pkg::DEBOUNCE_MAX_MS)) begin
            next_debounce = dipd_pkg::DEBOUNCE_MAX_MS;
        end else begin
            next_debounce = wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= dipd_pkg::CTRL_RST;
        end else if (wr_en && addr == dipd_pkg::CTRL_OFS) begin
            ctrl_q <= wdata[2:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            debounce_ms <= dipd_pkg::DEBOUNCE_RST_MS;
        end else if (wr_debounce) begin
            debounce_ms <= next_debounce;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            route <= dipd_pkg::ROUTE_RST;
        end else if (wr_en && addr == dipd_pkg::ROUTE_OFS) begin
            route <= wdata[11:0] & FITTED;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask <= dipd_pkg::MASK_RST;
        end else if (wr_en && addr == dipd_pkg::MASK_OFS) begin
            mask <= wdata[13:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse counters; a software write wins over a same-cycle count
    generate
        for (gi = 0; gi < N; gi++) begin : g_cnt
            assign count_wrap[gi] = event_vec[gi] && route[gi] && (count_q[gi] == 16'hFFFF)
                && !(wr_en && in_counters && cnt_idx == 4'(gi));
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    count_q[gi] <= 16'h0000;
                end else if (wr_en && in_counters && cnt_idx == 4'(gi)) begin
                    count_q[gi] <= wdata[15:0];
                end else if (event_vec[gi] && route[gi]) begin
                    count_q[gi] <= count_q[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Event outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            setpoint_event <= 12'h000;
            demand_start <= 1'b0;
        end else begin
            setpoint_event <= event_vec & ~route;
            demand_start <= ctrl_q.demand_sync && event_vec[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status and interrupt; a set wins over a clear
    assign status_set = {(|count_wrap), (ctrl_q.demand_sync && event_vec[0]), event_vec};
    assign status_clr = (wr_en && addr == dipd_pkg::STATUS_OFS) ? wdata[13:0] : 14'h0000;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status <= 14'h0000;
        end else begin
            status <= (status & ~status_clr) | status_set;
        end
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read path: data valid only in the cycle after the strobe
    always_comb begin
        read_mux = 32'h0000_0000;
        if (in_counters) begin
            read_mux = {16'h0000, count_q[cnt_idx]};
        end else if (in_aliases) begin
            read_mux = {25'h000_0000, debounce_ms};
        end else begin
            unique case (addr)
                dipd_pkg::CTRL_OFS: read_mux = {29'h0000_0000, ctrl_q};
                dipd_pkg::DEBOUNCE_OFS: read_mux = {25'h000_0000, debounce_ms};
                dipd_pkg::ROUTE_OFS: read_mux = {20'h0_0000, route};
                dipd_pkg::LEVEL_OFS: read_mux = {20'h0_0000, level & FITTED};
                dipd_pkg::STATUS_OFS: read_mux = {18'h0_0000, status};
                dipd_pkg::MASK_OFS: read_mux = {18'h0_0000, mask};
                dipd_pkg::FITTED_OFS: read_mux = {20'h0_0000, FITTED};
                default: read_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata <= read_mux;
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_sync_first_event;
        ctrl_q.demand_sync && event_vec[0];
    endsequence

    sequence s_counted_event;
        event_vec[0] && route[0] && !(wr_en && in_counters && cnt_idx == 4'h0);
    endsequence

    sequence s_counter_write;
        wr_en && in_counters && cnt_idx == 4'h0;
    endsequence

    sequence s_status_clear;
        wr_en && addr == dipd_pkg::STATUS_OFS;
    endsequence

    a_normal_edge_event: assert property (
        (!ctrl_q.transition_pulse_mode && !ctrl_q.invert) |-> event_vec == (rise & FITTED))
        else $error("normal polarity event mismatch");
    a_invert_edge_event: assert property (
        (!ctrl_q.transition_pulse_mode && ctrl_q.invert) |-> event_vec == (fall & FITTED))
        else $error("inverting polarity event mismatch");
    a_single_edge_once: assert property (
        (!ctrl_q.transition_pulse_mode && event_vec[0]) |-> level[0] != ctrl_q.invert)
        else $error("pulse mode event on wrong edge");
    a_transition_both_edges: assert property (
        ctrl_q.transition_pulse_mode |-> event_vec == ((rise | fall) & FITTED))
        else $error("transition mode event mismatch");
    a_polarity_ignored: assert property (
        (ctrl_q.transition_pulse_mode && $stable(ctrl_q.transition_pulse_mode) && fall[0])
        |-> event_vec[0])
        else $error("polarity affects transition mode");
    a_debounce_in_range: assert property (
        debounce_ms >= dipd_pkg::DEBOUNCE_MIN_MS && debounce_ms <= dipd_pkg::DEBOUNCE_MAX_MS)
        else $error("debounce time out of range");
    a_alias_shared: assert property (
        (wr_en && in_aliases) |=> debounce_ms == $past(next_debounce))
        else $error("alias write did not reach shared time");
    a_unfitted_silent: assert property ((event_vec & ~FITTED) == 12'h000)
        else $error("event on unfitted input");
    a_counter_increment: assert property (
        s_counted_event |=> count_q[0] == $past(count_q[0]) + 16'h0001)
        else $error("pulse counter missed an event");
    a_setpoint_routed: assert property (
        (event_vec[0] && !route[0]) |=> setpoint_event[0] ##1 !setpoint_event[0] || event_vec[0])
        else $error("setpoint event not raised");
    a_demand_start_pulse: assert property (s_sync_first_event |=> demand_start)
        else $error("demand start missing");
    a_demand_needs_sync: assert property (demand_start |-> $past(ctrl_q.demand_sync))
        else $error("demand start without sync mode");
    a_read_data_slot: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
        else $error("read data outside its slot");

    ////////////////////////////////////////////////////////////////////////////
    // Register, counter and status checks; input 0 stands for every input
    a_fitted_count: assert property (
        DI_COUNT >= dipd_pkg::MIN_INPUTS && DI_COUNT <= dipd_pkg::MAX_INPUTS)
        else $error("fitted input count out of range");
    a_route_fitted: assert property ((route & ~FITTED) == 12'h000)
        else $error("route bit on unfitted input");
    a_ctrl_write: assert property (
        (wr_en && addr == dipd_pkg::CTRL_OFS) |=> ctrl_q == $past(wdata[2:0]))
        else $error("control write lost");
    a_route_write: assert property (
        (wr_en && addr == dipd_pkg::ROUTE_OFS) |=> route == ($past(wdata[11:0]) & FITTED))
        else $error("route write lost");
    a_mask_write: assert property (
        (wr_en && addr == dipd_pkg::MASK_OFS) |=> mask == $past(wdata[13:0]))
        else $error("mask write lost");
    a_debounce_read: assert property (
        (rd_en && in_aliases) |=> rdata == 32'($past(debounce_ms)))
        else $error("alias read differs from shared time");
    a_level_read: assert property (
        (rd_en && addr == dipd_pkg::LEVEL_OFS) |=> rdata == 32'($past(level) & FITTED))
        else $error("level read mismatch");
    a_status_read: assert property (
        (rd_en && addr == dipd_pkg::STATUS_OFS) |=> rdata == 32'($past(status)))
        else $error("status read mismatch");
    a_counter_load: assert property (
        s_counter_write |=> count_q[0] == $past(wdata[15:0]))
        else $error("counter write lost");
    a_counter_steady: assert property (
        (!(event_vec[0] && route[0]) && !(wr_en && in_counters && cnt_idx == 4'h0))
        |=> $stable(count_q[0]))
        else $error("counter changed without cause");
    a_wrap_flagged: assert property (
        (s_counted_event ##0 (count_q[0] == 16'hFFFF)) |=> status[dipd_pkg::ST_WRAP_BIT])
        else $error("counter wrap not flagged");
    a_setpoint_source: assert property (
        setpoint_event[0] |-> $past(event_vec[0]) && !$past(route[0]))
        else $error("setpoint event without routed event");
    a_setpoint_pulse: assert property (setpoint_event[0] |=> !setpoint_event[0])
        else $error("setpoint event too long");
    a_demand_one_cycle: assert property (demand_start |=> !demand_start)
        else $error("demand start too long");
    a_demand_from_input: assert property (demand_start |-> $past(event_vec[0]))
        else $error("demand start without input event");
    a_demand_flagged: assert property (
        s_sync_first_event |=> status[dipd_pkg::ST_DEMAND_BIT])
        else $error("demand start not flagged");
    // Set wins over clear, so a same-cycle event keeps its bit
    a_status_set: assert property (status_set[0] |=> status[0])
        else $error("status bit not set by event");
    a_status_sticky: assert property ((status[0] && !status_clr[0]) |=> status[0])
        else $error("status bit dropped without clear");
    a_status_clear: assert property (
        (s_status_clear ##0 (wdata[0] && !status_set[0])) |=> !status[0])
        else $error("status bit not cleared by write");
endmodule : dipd_top
`default_nettype wire
